// ==== include/gpp_pkg.sv ====
// Package for the general purpose I/O port: register map, modes and sensitivity codes
package gpp_pkg;

    localparam int PIN_COUNT = 8;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [7:0] OFS_VALUE     = 8'h00;
    localparam logic [7:0] OFS_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_OPTION    = 8'h08;
    localparam logic [7:0] OFS_SENSE     = 8'h0C;
    localparam logic [7:0] OFS_GROUP     = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // Reset values
    localparam logic [7:0] RST_VALUE     = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OPTION    = 8'h00;
    localparam logic [7:0] RST_GROUP     = 8'h00;
    localparam logic [3:0] RST_SENSE     = 4'h0;

    // Sensitivity register: two bits per interrupt group
    localparam int SENSE_G0_LSB = 0;
    localparam int SENSE_G1_LSB = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin modes from direction and option bits
    localparam logic [1:0] MODE_FLOAT_IN  = 2'h0;
    localparam logic [1:0] MODE_IRQ_IN    = 2'h1;
    localparam logic [1:0] MODE_OD_OUT    = 2'h2;
    localparam logic [1:0] MODE_PP_OUT    = 2'h3;

    // Sensitivity codes
    typedef enum logic [1:0] {
        SENS_FALL_LOW = 2'h0,
        SENS_RISE     = 2'h1,
        SENS_FALL     = 2'h2,
        SENS_BOTH     = 2'h3
    } gpp_sense_t;

endpackage

// ==== rtl/gpp_irq_group.sv ====
// One external interrupt group: qualify enabled pins, OR them, hold the request
`timescale 1ns/100ps
module gpp_irq_group
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Pin side
    input  wire logic [WIDTH-1:0] pin_sync,
    input  wire logic [WIDTH-1:0] src_en,
    input  wire logic [1:0]       sense,
    input  wire logic             sense_wr,
    // CPU side
    input  wire logic             vector_fetch,
    output logic                  pending
);

    logic [WIDTH-1:0] pin_prev;
    logic [WIDTH-1:0] qualified;
    logic             event_hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    always_comb begin
        qualified = '0;
        for (int i = 0; i < WIDTH; i++) begin
            case (gpp_sense_t'(sense))
                SENS_FALL_LOW: qualified[i] = src_en[i] & ~pin_sync[i] & pin_prev[i];
                SENS_RISE:     qualified[i] = src_en[i] & pin_sync[i] & ~pin_prev[i];
                SENS_FALL:     qualified[i] = src_en[i] & ~pin_sync[i] & pin_prev[i];
                SENS_BOTH:     qualified[i] = src_en[i] & (pin_sync[i] ^ pin_prev[i]);
                default:       qualified[i] = 1'b0;
            endcase
            if (gpp_sense_t'(sense) == SENS_FALL_LOW) begin
                qualified[i] = src_en[i] & ~pin_sync[i];
            end
        end
        event_hit = |qualified;
    end

    // Sensitivity write discards, vector fetch clears, a new event wins over both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= 1'b0;
        end else if (event_hit) begin
            pending <= 1'b1;
        end else if (sense_wr || vector_fetch) begin
            pending <= 1'b0;
        end
    end

endmodule

// ==== rtl/gpp_port.sv ====
// Eight pin general purpose I/O port with AXI4-Lite registers and external interrupts
`timescale 1ns/100ps
// Summary of operation
// - Up to eight pins; bit x of each register but the sensitivity register belongs to pin x only.
// - Direction bit clear makes an input; value reads return the pin level.
// - Writing value of an input pin only loads the latch.
// - Direction bit set drives the latch out; reads return the latch.
// - Push-pull drives 0 and 1; open-drain drives 0 and releases on 1.
// - An interrupt input pin raises an external request on its event.
// - Enabled pins of a group are qualified by sensitivity, then ORed.
// - Request latch is hidden from software; vector fetch clears it.
// - Changing a group's sensitivity cancels its pending request.
// - Request reaches the CPU only with interrupt mode and mask inactive.
// - A peripheral claiming a pin overrides the standard configuration.
// - Peripheral outputs force output mode, push-pull or open-drain as chosen.
// - Peripheral inputs need input mode; value reads still show the pin.
// - Input pin with peripheral output reads back the peripheral's output.
// - Output pin with peripheral input feeds the peripheral the latch.
// - Direction,option: 00 float, 01 pull-up/irq, 10 open-drain, 11 push-pull.
module gpp_port
    import gpp_pkg::*;
#(
    parameter int          PINS     = PIN_COUNT,
    parameter logic [7:0]  IRQ_PINS = 8'hFF
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Pads
    input  wire logic [PINS-1:0]  pin_in,
    output logic [PINS-1:0]       pin_out,
    output logic [PINS-1:0]       pin_oe_n,
    output logic [PINS-1:0]       pin_pullup,
    // Alternate function
    input  wire logic [PINS-1:0]  alt_claim,
    input  wire logic [PINS-1:0]  alt_out_en,
    input  wire logic [PINS-1:0]  alt_out_od,
    input  wire logic [PINS-1:0]  alt_out,
    output logic [PINS-1:0]       alt_in,
    // CPU interrupt interface
    input  wire logic             irq_mask,
    input  wire logic [1:0]       vector_fetch,
    output logic [1:0]            ext_irq
);

    ////////////////////////////////////////////////////////////////////////////
    logic [PINS-1:0] port_pin_value;
    logic [PINS-1:0] port_pin_direction;
    logic [PINS-1:0] port_pin_option;
    logic [PINS-1:0] irq_group;
    logic [3:0]      ext_irq_sensitivity_reg;
    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    logic [1:0]      pending;
    logic [1:0]      sense_wr;

    logic [7:0]      aw_addr;
    logic            aw_have;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            w_have;
    logic            do_write;

    assign do_write = aw_have && w_have && !s_axi_bvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser; first stage is read by nothing else
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr <= OFS_GROUP && aw_addr[1:0] == 2'h0)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes: every register except the sensitivity register holds pin x in bit x
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pin_value          <= RST_VALUE;
            port_pin_direction      <= RST_DIRECTION;
            port_pin_option         <= RST_OPTION;
            irq_group               <= RST_GROUP;
            ext_irq_sensitivity_reg <= RST_SENSE;
            sense_wr                <= 2'h0;
        end else begin
            sense_wr <= 2'h0;
            if (do_write && w_strb[0]) begin
                case (aw_addr)
                    OFS_VALUE:     port_pin_value     <= w_data[PINS-1:0];
                    OFS_DIRECTION: port_pin_direction <= w_data[PINS-1:0];
                    OFS_OPTION:    port_pin_option    <= w_data[PINS-1:0];
                    OFS_GROUP:     irq_group          <= w_data[PINS-1:0];
                    OFS_SENSE: begin
                        ext_irq_sensitivity_reg <= w_data[3:0];
                        // Any write to the sensitivity register cancels the requests of both groups
                        sense_wr <= 2'h3;
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive and alternate function routing
    logic [PINS-1:0] eff_dir;
    logic [PINS-1:0] eff_od;
    logic [PINS-1:0] eff_val;
    logic [PINS-1:0] read_value;
    logic [PINS-1:0] irq_in_mode;

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            // Claimed peripheral output forces output mode
            eff_dir[i] = (alt_claim[i] && alt_out_en[i]) ? 1'b1
                                                          : port_pin_direction[i];
            eff_od[i]  = (alt_claim[i] && alt_out_en[i]) ? alt_out_od[i]
                                                          : !port_pin_option[i];
            eff_val[i] = (alt_claim[i] && alt_out_en[i]) ? alt_out[i]
                                                          : port_pin_value[i];
            // Read value: latch for outputs, pin for inputs, peripheral output on override of an input
            if (port_pin_direction[i]) begin
                read_value[i] = port_pin_value[i];
            end else if (alt_claim[i] && alt_out_en[i]) begin
                read_value[i] = alt_out[i];
            end else begin
                read_value[i] = pin_sync[i];
            end
            irq_in_mode[i] = IRQ_PINS[i] && !port_pin_direction[i]
                             && port_pin_option[i] && !alt_claim[i];
        end
    end

    // Pads hold their state in wait and halt: nothing here depends on power state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out    <= '0;
            pin_oe_n   <= '1;
            pin_pullup <= '0;
            alt_in     <= '0;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                pin_out[i]    <= eff_val[i] && !eff_od[i];
                // Open-drain drives only a low level
                pin_oe_n[i]   <= !(eff_dir[i] && (!eff_od[i] || !eff_val[i]));
                pin_pullup[i] <= !eff_dir[i] && port_pin_option[i];
                alt_in[i]     <= port_pin_direction[i] ? port_pin_value[i]
                                                       : pin_sync[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two interrupt groups; irq_group bit picks the group of each pin
    for (genvar g = 0; g < 2; g++) begin : grp
        logic [PINS-1:0] en;
        assign en = irq_in_mode & (g == 0 ? ~irq_group : irq_group);
        gpp_irq_group #(.WIDTH(PINS)) u_grp (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .pin_sync     (pin_sync),
            .src_en       (en),
            .sense        (ext_irq_sensitivity_reg[2*g +: 2]),
            .sense_wr     (sense_wr[g]),
            .vector_fetch (vector_fetch[g]),
            .pending      (pending[g])
        );
    end

    // Masked CPU sees no request; pending stays held for later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_irq <= 2'h0;
        end else begin
            ext_irq <= pending & {2{!irq_mask}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel, one word at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    OFS_VALUE:     s_axi_rdata <= {24'h000000, read_value};
                    OFS_DIRECTION: s_axi_rdata <= {24'h000000, port_pin_direction};
                    OFS_OPTION:    s_axi_rdata <= {24'h000000, port_pin_option};
                    OFS_SENSE:     s_axi_rdata <= {28'h0000000, ext_irq_sensitivity_reg};
                    OFS_GROUP:     s_axi_rdata <= {24'h000000, irq_group};
                    OFS_STATUS:    s_axi_rdata <= {24'h000000, pin_sync};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sync_delay_a: assert property (
        $past(aresetn, 2) && !$past(port_pin_direction[0]) && !$past(alt_claim[0])
        && !port_pin_direction[0] && !alt_claim[0]
        |-> read_value[0] == $past(pin_in[0], 2))
        else $error("Pin read not two flops behind pad");
    latch_read_a: assert property (
        port_pin_direction[1] |-> read_value[1] == port_pin_value[1])
        else $error("Output pin reads wrong value");
    od_release_a: assert property (
        $past(!alt_claim[5] && port_pin_direction[5] && !port_pin_option[5]
              && port_pin_value[5]) |-> pin_oe_n[5])
        else $error("Open-drain high not released");
    pp_drive_a: assert property (
        $past(!alt_claim[4] && port_pin_direction[4] && port_pin_option[4])
        |-> !pin_oe_n[4] && pin_out[4] == $past(port_pin_value[4]))
        else $error("Push-pull level wrong");
    input_hiz_a: assert property (
        $past(!port_pin_direction[4] && !alt_claim[4]) |-> pin_oe_n[4])
        else $error("Input pin driven");
    alt_force_a: assert property (
        $past(alt_claim[3] && alt_out_en[3] && !alt_out_od[3])
        |-> !pin_oe_n[3] && pin_out[3] == $past(alt_out[3]))
        else $error("Peripheral output not forced");
    mask_gate_a: assert property (
        $past(irq_mask) |-> ext_irq == 2'h0)
        else $error("Masked request reached CPU");
    sense_cancel_a: assert property (
        sense_wr[0] && !grp[0].u_grp.event_hit |=> !pending[0])
        else $error("Sensitivity write kept request");
    fetch_clear_a: assert property (
        vector_fetch[1] && !grp[1].u_grp.event_hit && !sense_wr[1] |=> !pending[1])
        else $error("Vector fetch did not clear");
    bresp_timing_a: assert property (
        do_write |=> s_axi_bvalid)
        else $error("Write response late");

    write_cov: cover property (do_write);
    irq_cov:   cover property (ext_irq[0]);
    alt_cov:   cover property (alt_claim[3] && alt_out_en[3] && !port_pin_direction[3]);
    read_cov:  cover property (s_axi_rvalid && s_axi_rready);

endmodule

// ==== verification/gpp_pad_model.sv ====
// Board-side model of the pads: external drivers, pull-ups and undriven lines
`timescale 1ns/100ps
module gpp_pad_model (
    // Clock
    input  wire logic       aclk,
    // Device pad controls
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_pullup,
    // Bench-controlled external drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_lvl,
    // Resolved pad levels
    output logic      [7:0] pad
);
    logic [7:0] drift = 8'h00;

    ////////////////////////////////////////
    // Undriven pads wander, so a stale level never passes for a real one
    always_ff @(posedge aclk) begin
        drift <= ~drift;
    end

    ////////////////////////////////////////
    // Device driver wins; the bench avoids contention on purpose
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_n[i] === 1'h0) begin
                pad[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_lvl[i];
            end else if (pin_pullup[i]) begin
                pad[i] = 1'h1;
            end else begin
                pad[i] = drift[i];
            end
        end
    end
endmodule

// ==== verification/gpp_port_test.sv ====
// Bench for the I/O port: registers, pads, interrupts and alternate functions
`timescale 1ns/100ps
module gpp_port_test
    import gpp_pkg::*;
();
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, irq_mask = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ext_irq, r, vector_fetch = 2'h0;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup, alt_in;
    logic [7:0]  alt_claim = 8'h00, alt_out_en = 8'h00, alt_out_od = 8'h00, alt_out = 8'h00;
    logic [7:0]  ext_en = 8'hFF, ext_lvl = 8'hA5;
    int          n_errors = 0, check_count = 0;

    always #25 aclk = ~aclk;

    gpp_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
        .pin_oe_n, .pin_pullup, .alt_claim, .alt_out_en, .alt_out_od, .alt_out, .alt_in,
        .irq_mask, .vector_fetch, .ext_irq);

    gpp_pad_model pads (.aclk, .pin_out, .pin_oe_n, .pin_pullup, .ext_en, .ext_lvl,
        .pad(pin_in));

    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wcyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Address and data offered together; each dropped once its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                n = 99;
            end
        end
        if (n == 40) begin
            n_errors++;
            give_verdict();
        end
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (n < 40) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'h0;
                n = 99;
            end
        end
        if (n == 40) begin
            n_errors++;
            give_verdict();
        end
        @(posedge aclk);
    endtask

    task automatic wrc(input logic [7:0] a, input logic [7:0] v);
        wr(a, v, 4'h1);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk("rdata", {24'h0, e}, d);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    task automatic fetch(input logic [1:0] g);
        vector_fetch <= g;
        @(posedge aclk);
        vector_fetch <= 2'h0;
        @(posedge aclk);
    endtask

    task automatic irq(input logic [1:0] e, input int n);
        wcyc(n);
        chk("ext_irq", {30'h0, e}, {30'h0, ext_irq});
    endtask

    ////////////////////////////////////////
    initial begin
        wcyc(6);
        aresetn <= 1'h1;
        wcyc(4);
        chk("pin_oe_n", 32'hFF, {24'h0, pin_oe_n});
        rdc(OFS_DIRECTION, RST_DIRECTION);
        rdc(OFS_OPTION, RST_OPTION);
        rdc(OFS_VALUE, 8'hA5);
        rdc(OFS_STATUS, 8'hA5);
        wrc(OFS_VALUE, 8'h3C);
        chk("pin_oe_n", 32'hFF, {24'h0, pin_oe_n});
        rdc(OFS_VALUE, 8'hA5);
        // Refused accesses leave the map untouched
        rd(8'h18);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("rdata", 32'h0, d);
        wr(OFS_STATUS, 8'hFF, 4'h1);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(8'h02, 8'hFF, 4'h1);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(OFS_DIRECTION, 8'hFF, 4'h0);
        rdc(OFS_DIRECTION, 8'h00);
        // Upper nibble outputs: 7,5 open-drain, 6,4 push-pull; latch loaded first
        ext_en <= 8'h0F;
        wrc(OFS_OPTION, 8'h55);
        wrc(OFS_DIRECTION, 8'hF0);
        wcyc(2);
        chk("pin_oe_n", 32'h2F, {24'h0, pin_oe_n});
        chk("pin_out", 32'h10, {24'h0, pin_out & 8'hD0});
        chk("pin_pullup", 32'h05, {24'h0, pin_pullup});
        rdc(OFS_VALUE, 8'h35);
        wrc(OFS_DIRECTION, 8'h00);
        wrc(OFS_OPTION, 8'h01);
        ext_en <= 8'hFF;
        ext_lvl <= 8'h01;
        wrc(OFS_GROUP, 8'h02);
        // Every sensitivity code on pin 0, group 0
        for (int c = 0; c < 4; c++) begin
            wrc(OFS_SENSE, 8'(c));
            irq(2'h0, 3);
            ext_lvl <= 8'h00;
            irq({1'h0, c != 1}, 5);
            fetch(2'h1);
            irq({1'h0, c == 0}, 3);
            ext_lvl <= 8'h01;
            irq({1'h0, c != 2}, 5);
            fetch(2'h1);
            irq(2'h0, 3);
        end
        // Group 1 falling edge on pin 1, masked, then unmasked to reach the CPU
        wrc(OFS_OPTION, 8'h03);
        wrc(OFS_SENSE, 8'h09);
        ext_lvl <= 8'h03;
        irq(2'h0, 5);
        irq_mask <= 1'h1;
        ext_lvl <= 8'h01;
        irq(2'h0, 5);
        irq_mask <= 1'h0;
        irq(2'h2, 2);
        // Group 1 vector fetch clears, then a fresh falling edge re-arms it
        fetch(2'h2);
        irq(2'h0, 3);
        ext_lvl <= 8'h03;
        wcyc(3);
        ext_lvl <= 8'h01;
        irq(2'h2, 5);
        wrc(OFS_SENSE, 8'h09);
        irq(2'h0, 2);
        wrc(OFS_OPTION, 8'h00);
        ext_lvl <= 8'h00;
        wcyc(3);
        ext_lvl <= 8'h01;
        irq(2'h0, 5);
        // Peripheral drives pin 3, reads pins 1 and 2
        ext_en <= 8'hF3;
        ext_lvl <= 8'h02;
        alt_claim <= 8'h0E;
        alt_out_en <= 8'h08;
        alt_out <= 8'h08;
        wrc(OFS_VALUE, 8'h04);
        wrc(OFS_DIRECTION, 8'h04);
        wcyc(3);
        chk("pin_oe_n", 32'h0, {24'h0, pin_oe_n & 8'h08});
        chk("pin_out", 32'h08, {24'h0, pin_out & 8'h08});
        chk("alt_in", 32'h06, {24'h0, alt_in & 8'h06});
        rdc(OFS_VALUE, 8'h0E);
        alt_out_od <= 8'h08;
        wcyc(3);
        chk("pin_oe_n", 32'h08, {24'h0, pin_oe_n & 8'h08});
        give_verdict();
    end
endmodule
